// *** tb/board_pins.sv ***
// Purpose: board side of the shared indicator and strap pins
// Assumes: strap resistors set the level of a released pin
// Notes: LEDs load the pin lightly, so the driver wins when enabled
`timescale 1ns/1ps
module board_pins #(
  parameter logic STRAP_LINK = 1'b1,
  parameter logic STRAP_SPEED = 1'b0,
  parameter logic STRAP_ACT = 1'b1
) (
  // driven side of each pin
  input wire logic link_out,
  input wire logic link_oe,
  input wire logic speed_out,
  input wire logic speed_oe,
  input wire logic act_out,
  input wire logic act_oe,
  // resolved pin levels
  output logic link_pin,
  output logic speed_pin,
  output logic act_pin
);
  // a released pin rests at its strap level
  assign link_pin = link_oe ? link_out : STRAP_LINK;
  assign speed_pin = speed_oe ? speed_out : STRAP_SPEED;
  assign act_pin = act_oe ? act_out : STRAP_ACT;
endmodule // board_pins

// *** tb/led_ind_sva.sv ***
// Purpose: checks indicator pins and register answers at the block ports
// Assumes: one clock domain, shadows of the writable fields except advertisement kept here
// Notes: pin relations are only judged while the shadows stand still
`timescale 1ns/1ps
module led_ind_sva #(
  parameter int unsigned TICK_DIV = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_rvalid,
  // transceiver status
  input wire logic link_good,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic collision,
  input wire logic tx_active,
  input wire logic rx_active,
  input wire logic indicator_mode_strap,
  // pins
  input wire logic link_indicator_in,
  input wire logic link_indicator_out,
  input wire logic link_indicator_oe,
  input wire logic speed_indicator_in,
  input wire logic speed_indicator_out,
  input wire logic speed_indicator_oe,
  input wire logic activity_indicator_in,
  input wire logic activity_indicator_out,
  input wire logic activity_indicator_oe,
  input wire logic collision_out,
  input wire logic collision_oe
);
  logic started_r, started_nxt;
  logic [15:0] led_r, led_nxt, multi_configurable_indicator_r, multi_configurable_indicator_nxt;
  logic [1:0] mode_r, mode_nxt;
  // next values of the register shadows
  always_comb begin
    started_nxt = 1'b1;
    led_nxt = led_r;
    multi_configurable_indicator_nxt = multi_configurable_indicator_r;
    mode_nxt = mode_r;
    if (!started_r) mode_nxt = {1'b0, indicator_mode_strap};
    if (started_r && reg_wr && reg_addr == 8'h18) led_nxt = reg_wdata & 16'h07c0;
    if (started_r && reg_wr && reg_addr == 8'h25) multi_configurable_indicator_nxt = reg_wdata & 16'h01ff;
    if (started_r && reg_wr && reg_addr == 8'h19) mode_nxt = reg_wdata[6:5];
  end
  // shadow registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      started_r <= 1'b0;
      led_r <= 16'h0400;
      multi_configurable_indicator_r <= 16'h0080;
      mode_r <= 2'h0;
    end else begin
      started_r <= started_nxt;
      led_r <= led_nxt;
      multi_configurable_indicator_r <= multi_configurable_indicator_nxt;
      mode_r <= mode_nxt;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  sequence s_steady;
    $past(started_r) && $stable(led_r) && $stable(multi_configurable_indicator_r) && $stable(mode_r);
  endsequence
  sequence s_read(a);
    reg_rd && started_r && reg_addr == a;
  endsequence
  a_pins_released: assert property ($rose(rst_n) |-> !link_indicator_oe && !speed_indicator_oe &&
    !activity_indicator_oe ##1 link_indicator_oe && speed_indicator_oe && activity_indicator_oe)
    else $error("indicator enables wrong after reset release");
  a_pins_driven: assert property ($past(started_r) |-> link_indicator_oe && speed_indicator_oe &&
    activity_indicator_oe && collision_oe) else $error("indicator pin not driven");
  a_speed_map: assert property (s_steady ##0 multi_configurable_indicator_r[2:0] != 3'h2 |->
    speed_indicator_out == ($past(speed_100) ^ led_r[7])) else $error("speed pin wrong");
  a_link_mode1: assert property (s_steady ##0 mode_r[0] && multi_configurable_indicator_r[2:0] != 3'h1 |->
    link_indicator_out == ($past(link_good) ^ led_r[6])) else $error("link pin wrong in mode 1");
  a_act_collision: assert property (s_steady ##0 mode_r == 2'h0 && multi_configurable_indicator_r[2:0] != 3'h3 |->
    activity_indicator_out == ($past(collision) ^ led_r[8])) else $error("activity pin not collision");
  a_act_duplex: assert property (s_steady ##0 mode_r == 2'h2 && multi_configurable_indicator_r[2:0] != 3'h3 |->
    activity_indicator_out == ($past(full_duplex) ^ led_r[8])) else $error("activity pin not duplex");
  a_col_normal: assert property (s_steady ##0 multi_configurable_indicator_r[2:0] != 3'h4 |-> collision_out == $past(collision))
    else $error("collision pin wrong");
  a_col_replaced: assert property (s_steady ##0 multi_configurable_indicator_r[8:0] == 9'h0ac |->
    collision_out == $past(speed_100)) else $error("collision pin not replaced");
  a_rdata_led: assert property (s_read(8'h18) |=> reg_rvalid && reg_rdata == $past(led_r))
    else $error("led_control read wrong");
  a_rdata_multi: assert property (s_read(8'h25) |=> reg_rvalid && reg_rdata == $past(multi_configurable_indicator_r))
    else $error("multi_led_control read wrong");
endmodule // led_ind_sva

// *** tb/tb_top.sv ***
// Purpose: register and pin level tests of the indicator block
// Assumes: straps link 1, speed 0, activity 1, mode strap 1
// Notes: short tick divider keeps blink and stretch times small
`timescale 1ns/1ps
module tb_top;
  localparam int unsigned TICK_DIV = 4;
  localparam logic [11:0] MULTI_EXP = 12'h131;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reg_wr = 1'b0, reg_rd = 1'b0, mode_strap = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic [15:0] reg_rdata;
  logic link_good = 1'b0, speed_100 = 1'b0, full_duplex = 1'b0;
  logic collision = 1'b0, tx_active = 1'b0, rx_active = 1'b0;
  logic reg_rvalid, link_out, link_oe, speed_out, speed_oe, act_out, act_oe;
  logic collision_out, collision_oe, link_pin, speed_pin, act_pin;
  int num_errors = 0;
  int num_checks = 0;
  int half;
  // core clock
  always #50 clk = ~clk;
  phy_led_indicator_control #(.TICK_DIV(TICK_DIV)) i_phy_led_indicator_control (
    .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .link_good(link_good),
    .speed_100(speed_100), .full_duplex(full_duplex), .collision(collision), .tx_active(tx_active),
    .rx_active(rx_active), .indicator_mode_strap(mode_strap), .link_indicator_in(link_pin),
    .link_indicator_out(link_out), .link_indicator_oe(link_oe), .speed_indicator_in(speed_pin),
    .speed_indicator_out(speed_out), .speed_indicator_oe(speed_oe), .activity_indicator_in(act_pin),
    .activity_indicator_out(act_out), .activity_indicator_oe(act_oe), .collision_out(collision_out),
    .collision_oe(collision_oe));
  board_pins i_board_pins (.link_out(link_out), .link_oe(link_oe), .speed_out(speed_out),
    .speed_oe(speed_oe), .act_out(act_out), .act_oe(act_oe), .link_pin(link_pin),
    .speed_pin(speed_pin), .act_pin(act_pin));
  // compare and count
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic pin(input string what, input logic exp, input logic got);
    chk(what, {15'h0000, exp}, {15'h0000, got});
  endtask
  task automatic step(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one register write, strobe held for one rising edge
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  // one register read, answer checked one cycle later
  task automatic rd(input logic [7:0] a, input logic [15:0] exp, input string what);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    pin({what, "_valid"}, 1'b1, reg_rvalid);
    chk(what, exp, reg_rdata);
  endtask
  task automatic summarize;
    if (num_errors == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    summarize();
  end
  // main sequence
  initial begin
    step(16);
    rst_n = 1'b1;
    step(2);
    rd(8'h18, 16'h0400, "led_control");
    rd(8'h25, 16'h0080, "multi_led_control");
    rd(8'h19, 16'h0020, "phy_control");
    rd(8'h04, 16'h0180, "advertisement");
    rd(8'h30, 16'h0000, "unmapped");
    link_good = 1'b1;
    speed_100 = 1'b1;
    step(3);
    pin("link_ind", 1'b1, link_pin);
    pin("speed_ind", 1'b1, speed_pin);
    pin("act_idle", 1'b0, act_pin);
    tx_active = 1'b1;
    step(1);
    tx_active = 1'b0;
    step(100);
    pin("act_stretch", 1'b1, act_pin);
    step(150);
    pin("act_stretch_end", 1'b0, act_pin);
    wr(8'h18, 16'hffff);
    rd(8'h18, 16'h07c0, "led_control_mask");
    step(3);
    pin("link_inverted", 1'b0, link_pin);
    pin("speed_inverted", 1'b0, speed_pin);
    pin("act_inverted", 1'b1, act_pin);
    wr(8'h18, 16'h0000);
    for (int m = 0; m < 2; m++) begin
      wr(8'h19, m[0] ? 16'h0040 : 16'h0000);
      for (int v = 0; v < 2; v++) begin
        collision = v[0];
        full_duplex = !v[0];
        speed_100 = v[0];
        step(3);
        pin("act_mode", m[0] ? !v[0] : v[0], act_pin);
        pin("speed_mode", v[0], speed_pin);
      end
    end
    // every blink rate code: half periods of 25, 50, 100 and 250 ticks
    for (int r = 0; r < 4; r++) begin
      wr(8'h18, {5'h00, r[1:0], 9'h000});
      half = (r == 3) ? 1000 : 100 << r;
      tx_active = 1'b1;
      step(half / 2);
      pin("blink_on", 1'b1, link_pin);
      step(half);
      pin("blink_off", 1'b0, link_pin);
      step(half);
      pin("blink_again", 1'b1, link_pin);
      tx_active = 1'b0;
      step(450);
      pin("link_steady", 1'b1, link_pin);
    end
    speed_100 = 1'b1;
    full_duplex = 1'b0;
    collision = 1'b1;
    for (int s = 0; s < 12; s++) begin
      wr(8'h25, {9'h001, s[3:0], 3'h4});
      step(3);
      pin("multi_on_col", MULTI_EXP[s], collision_out);
    end
    wr(8'h25, 16'h00a1);
    step(3);
    pin("multi_on_link", 1'b1, link_pin);
    collision = 1'b0;
    step(3);
    pin("multi_on_link_off", 1'b0, link_pin);
    // routed to speed pin with 10M source, then to activity pin with link source
    wr(8'h25, 16'h00b2);
    step(3);
    pin("multi_on_speed", 1'b0, speed_pin);
    wr(8'h25, 16'h0083);
    step(3);
    pin("multi_on_act", 1'b1, act_pin);
    wr(8'h25, 16'hffff);
    rd(8'h25, 16'h01ff, "multi_led_control_mask");
    rst_n = 1'b0;
    mode_strap = 1'b0;
    step(2);
    pin("oe_in_reset", 1'b0, link_oe);
    pin("strap_level", 1'b1, act_pin);
    rst_n = 1'b1;
    step(2);
    rd(8'h19, 16'h0000, "phy_control_again");
    rd(8'h25, 16'h0080, "multi_after_reset");
    summarize();
  end
endmodule // tb_top
bind phy_led_indicator_control led_ind_sva #(.TICK_DIV(TICK_DIV)) i_led_ind_sva (
  .clk(clk), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .link_good(link_good), .speed_100(speed_100),
  .full_duplex(full_duplex), .collision(collision), .tx_active(tx_active), .rx_active(rx_active),
  .indicator_mode_strap(indicator_mode_strap), .link_indicator_in(link_indicator_in),
  .link_indicator_out(link_indicator_out), .link_indicator_oe(link_indicator_oe),
  .speed_indicator_in(speed_indicator_in), .speed_indicator_out(speed_indicator_out),
  .speed_indicator_oe(speed_indicator_oe), .activity_indicator_in(activity_indicator_in),
  .activity_indicator_out(activity_indicator_out), .activity_indicator_oe(activity_indicator_oe),
  .collision_out(collision_out), .collision_oe(collision_oe));

// *** verilog/led_ind_pkg.sv ***
// Purpose: shared constants for the status indicator block
// Assumes: 10 MHz core clock, 16-bit management registers
// Notes: timing figures are kept in their own unit, counts derived
package led_ind_pkg;

  // core clock
  localparam int unsigned CLK_PERIOD_NS = 100;

  // base time step of the indicator logic: one millisecond
  localparam int unsigned TICK_NS = 1000000;
  localparam int unsigned TICK_CYCLES = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // register addresses
  localparam logic [7:0] ADDR_ADVERTISE = 8'h04;
  localparam logic [7:0] ADDR_LED_CONTROL = 8'h18;
  localparam logic [7:0] ADDR_PHY_CONTROL = 8'h19;
  localparam logic [7:0] ADDR_MULTI_LED_CONTROL = 8'h25;

  // phy_control: indicator mode select field
  localparam int unsigned MODE_LSB = 5;
  localparam int unsigned MODE_MSB = 6;

  // led_control: polarity field (bit 6 link, 7 speed, 8 activity) and blink rate
  localparam int unsigned POL_LSB = 6;
  localparam int unsigned POL_MSB = 8;
  localparam int unsigned RATE_LSB = 9;
  localparam int unsigned RATE_MSB = 10;
  localparam logic [15:0] LED_CONTROL_RESET = 16'h0400; // rate code 2'b10 = 5 Hz
  localparam logic [15:0] LED_CONTROL_MASK = 16'h07c0;

  // multi_led_control: route, source and stretch fields
  localparam int unsigned ROUTE_LSB = 0;
  localparam int unsigned ROUTE_MSB = 2;
  localparam int unsigned SRC_LSB = 3;
  localparam int unsigned SRC_MSB = 6;
  localparam int unsigned STRETCH_LSB = 7;
  localparam int unsigned STRETCH_MSB = 8;
  localparam logic [15:0] MULTI_LED_CONTROL_RESET = 16'h0080; // not routed, 50 ms stretch
  localparam logic [15:0] MULTI_LED_CONTROL_MASK = 16'h01ff;

  // phy_control and advertisement writable bits held here
  localparam logic [15:0] PHY_CONTROL_MASK = 16'h0060;
  localparam logic [15:0] ADVERTISE_MASK = 16'h01e0;
  localparam int unsigned ADV_LSB = 5;
  localparam int unsigned ADV_MSB = 8;

  // routes of the multi-configurable indicator
  localparam logic [2:0] ROUTE_NONE = 3'h0;
  localparam logic [2:0] ROUTE_LINK = 3'h1;
  localparam logic [2:0] ROUTE_SPEED = 3'h2;
  localparam logic [2:0] ROUTE_ACT = 3'h3;
  localparam logic [2:0] ROUTE_COL = 3'h4;

  // sources of the multi-configurable indicator
  localparam logic [3:0] SRC_LINK = 4'h0;
  localparam logic [3:0] SRC_ANY_ACT = 4'h1;
  localparam logic [3:0] SRC_TX = 4'h2;
  localparam logic [3:0] SRC_RX = 4'h3;
  localparam logic [3:0] SRC_COL = 4'h4;
  localparam logic [3:0] SRC_100M = 4'h5;
  localparam logic [3:0] SRC_10M = 4'h6;
  localparam logic [3:0] SRC_FULL_DUPLEX = 4'h7;
  localparam logic [3:0] SRC_LINK_BLINK = 4'h8;
  localparam logic [3:0] SRC_STRETCH = 4'h9;
  localparam logic [3:0] SRC_FAST_FULL_LINK = 4'ha;

  // blink half periods in ms: codes 0..3 = 20, 10, 5, 2 Hz
  localparam int unsigned BLINK_HALF_MS_20HZ = 25;
  localparam int unsigned BLINK_HALF_MS_10HZ = 50;
  localparam int unsigned BLINK_HALF_MS_5HZ = 100;
  localparam int unsigned BLINK_HALF_MS_2HZ = 250;

  // activity stretch in ms: codes 0..3
  localparam int unsigned STRETCH_MS_0 = 25;
  localparam int unsigned STRETCH_MS_1 = 50;
  localparam int unsigned STRETCH_MS_2 = 100;
  localparam int unsigned STRETCH_MS_3 = 200;

endpackage

// *** verilog/phy_led_indicator_control.sv ***
// Purpose: status indicator pins of a 10/100 transceiver, with strap capture
// Assumes: status inputs synchronous to clk, management register port
// Notes: indicator pins are released while reset is low
`timescale 1ns/1ps
module phy_led_indicator_control #(
  parameter int unsigned TICK_DIV = led_ind_pkg::TICK_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // management register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  output logic [15:0] reg_rdata,
  output logic reg_rvalid,
  // transceiver status
  input wire logic link_good,
  input wire logic speed_100,
  input wire logic full_duplex,
  input wire logic collision,
  input wire logic tx_active,
  input wire logic rx_active,
  // mode strap pin
  input wire logic indicator_mode_strap,
  // link indicator pin, also autoneg_mode_strap_low
  input wire logic link_indicator_in,
  output logic link_indicator_out,
  output logic link_indicator_oe,
  // speed indicator pin, also autoneg_mode_strap_high
  input wire logic speed_indicator_in,
  output logic speed_indicator_out,
  output logic speed_indicator_oe,
  // activity indicator pin, also autoneg_enable_strap
  input wire logic activity_indicator_in,
  output logic activity_indicator_out,
  output logic activity_indicator_oe,
  // collision pin
  output logic collision_out,
  output logic collision_oe
);

  typedef enum logic [1:0] {MODE_PULSE, MODE_COLLISION, MODE_DUPLEX} led_mode_t;

  logic tick;
  // register file
  logic [15:0] led_control_r, led_control_nxt;
  logic [15:0] phy_control_r, phy_control_nxt;
  logic [15:0] multi_led_control_r, multi_led_control_nxt;
  logic [15:0] advertisement_register_r, advertisement_register_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  logic strap_done_r, strap_done_nxt;
  // activity and blink state
  logic [7:0] stretch_r, stretch_nxt;
  logic stretched_prev_r, stretched_prev_nxt;
  logic [7:0] blink_cnt_r, blink_cnt_nxt;
  logic blink_phase_r, blink_phase_nxt;
  // pin drive
  logic [3:0] pin_r, pin_nxt;
  // decoded values
  logic [3:0] strap_adv;
  logic [7:0] stretch_len;
  logic [7:0] blink_half;
  logic any_act;
  logic stretched;
  logic link_blink;
  logic multi_configurable_indicator;
  led_mode_t indicator_mode_select;
  logic [2:0] route;
  logic [2:0] polarity;

  // millisecond enable
  tick_divider #(
    .DIV(TICK_DIV)
  ) u_tick (
    .clk(clk),
    .rst_n(rst_n),
    .tick(tick)
  );

  // strap decode: forced mode advertises one ability, autoneg a set
  always_comb begin
    case ({activity_indicator_in, speed_indicator_in, link_indicator_in})
      3'h0: strap_adv = 4'h1;
      3'h1: strap_adv = 4'h2;
      3'h2: strap_adv = 4'h4;
      3'h3: strap_adv = 4'h8;
      3'h4: strap_adv = 4'h3;
      3'h5: strap_adv = 4'hc;
      3'h6: strap_adv = 4'h5;
      default: strap_adv = 4'hf;
    endcase
  end

  // register file next state, straps taken on the first edge after release
  always_comb begin
    led_control_nxt = led_control_r;
    phy_control_nxt = phy_control_r;
    multi_led_control_nxt = multi_led_control_r;
    advertisement_register_nxt = advertisement_register_r;
    strap_done_nxt = 1'b1;
    rvalid_nxt = reg_rd;
    rdata_nxt = rdata_r;
    if (!strap_done_r) begin
      advertisement_register_nxt[led_ind_pkg::ADV_MSB:led_ind_pkg::ADV_LSB] = strap_adv;
      phy_control_nxt[led_ind_pkg::MODE_LSB] = indicator_mode_strap;
    end else if (reg_wr) begin
      case (reg_addr)
        led_ind_pkg::ADDR_LED_CONTROL: led_control_nxt = reg_wdata & led_ind_pkg::LED_CONTROL_MASK;
        led_ind_pkg::ADDR_PHY_CONTROL: phy_control_nxt = reg_wdata & led_ind_pkg::PHY_CONTROL_MASK;
        led_ind_pkg::ADDR_MULTI_LED_CONTROL: begin
          multi_led_control_nxt = reg_wdata & led_ind_pkg::MULTI_LED_CONTROL_MASK;
        end
        led_ind_pkg::ADDR_ADVERTISE: begin
          advertisement_register_nxt = reg_wdata & led_ind_pkg::ADVERTISE_MASK;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        led_ind_pkg::ADDR_LED_CONTROL: rdata_nxt = led_control_r;
        led_ind_pkg::ADDR_PHY_CONTROL: rdata_nxt = phy_control_r;
        led_ind_pkg::ADDR_MULTI_LED_CONTROL: rdata_nxt = multi_led_control_r;
        led_ind_pkg::ADDR_ADVERTISE: rdata_nxt = advertisement_register_r;
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  // register file flops; pins stay released until straps are taken
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      led_control_r <= led_ind_pkg::LED_CONTROL_RESET;
      phy_control_r <= 16'h0000;
      multi_led_control_r <= led_ind_pkg::MULTI_LED_CONTROL_RESET;
      advertisement_register_r <= 16'h0000;
      rdata_r <= 16'h0000;
      rvalid_r <= 1'b0;
      strap_done_r <= 1'b0;
    end else begin
      led_control_r <= led_control_nxt;
      phy_control_r <= phy_control_nxt;
      multi_led_control_r <= multi_led_control_nxt;
      advertisement_register_r <= advertisement_register_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      strap_done_r <= strap_done_nxt;
    end
  end

  // field decode
  always_comb begin
    case (phy_control_r[led_ind_pkg::MODE_MSB:led_ind_pkg::MODE_LSB])
      2'h0: indicator_mode_select = MODE_COLLISION;
      2'h2: indicator_mode_select = MODE_DUPLEX;
      default: indicator_mode_select = MODE_PULSE;
    endcase
    case (led_control_r[led_ind_pkg::RATE_MSB:led_ind_pkg::RATE_LSB])
      2'h0: blink_half = 8'(led_ind_pkg::BLINK_HALF_MS_20HZ);
      2'h1: blink_half = 8'(led_ind_pkg::BLINK_HALF_MS_10HZ);
      2'h2: blink_half = 8'(led_ind_pkg::BLINK_HALF_MS_5HZ);
      default: blink_half = 8'(led_ind_pkg::BLINK_HALF_MS_2HZ);
    endcase
    case (multi_led_control_r[led_ind_pkg::STRETCH_MSB:led_ind_pkg::STRETCH_LSB])
      2'h0: stretch_len = 8'(led_ind_pkg::STRETCH_MS_0);
      2'h1: stretch_len = 8'(led_ind_pkg::STRETCH_MS_1);
      2'h2: stretch_len = 8'(led_ind_pkg::STRETCH_MS_2);
      default: stretch_len = 8'(led_ind_pkg::STRETCH_MS_3);
    endcase
    route = multi_led_control_r[led_ind_pkg::ROUTE_MSB:led_ind_pkg::ROUTE_LSB];
    polarity = led_control_r[led_ind_pkg::POL_MSB:led_ind_pkg::POL_LSB];
  end

  assign any_act = tx_active | rx_active;
  assign stretched = any_act | (stretch_r != 8'h00);

  // stretch and blink next state
  always_comb begin
    stretch_nxt = stretch_r;
    blink_cnt_nxt = blink_cnt_r;
    blink_phase_nxt = blink_phase_r;
    stretched_prev_nxt = stretched;
    if (any_act) begin
      stretch_nxt = stretch_len;
    end else if (tick && stretch_r != 8'h00) begin
      stretch_nxt = stretch_r - 8'h01;
    end
    if (stretched && !stretched_prev_r) begin
      blink_cnt_nxt = 8'h00;
      blink_phase_nxt = 1'b0;
    end else if (tick) begin
      if (blink_cnt_r >= blink_half - 8'h01) begin
        blink_cnt_nxt = 8'h00;
        blink_phase_nxt = !blink_phase_r;
      end else begin
        blink_cnt_nxt = blink_cnt_r + 8'h01;
      end
    end
  end

  // stretch and blink flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stretch_r <= 8'h00;
      stretched_prev_r <= 1'b0;
      blink_cnt_r <= 8'h00;
      blink_phase_r <= 1'b0;
    end else begin
      stretch_r <= stretch_nxt;
      stretched_prev_r <= stretched_prev_nxt;
      blink_cnt_r <= blink_cnt_nxt;
      blink_phase_r <= blink_phase_nxt;
    end
  end

  // link with blink off-phase during activity
  assign link_blink = link_good & !(stretched & blink_phase_r);

  // multi-configurable source select
  always_comb begin
    case (multi_led_control_r[led_ind_pkg::SRC_MSB:led_ind_pkg::SRC_LSB])
      led_ind_pkg::SRC_LINK: multi_configurable_indicator = link_good;
      led_ind_pkg::SRC_ANY_ACT: multi_configurable_indicator = any_act;
      led_ind_pkg::SRC_TX: multi_configurable_indicator = tx_active;
      led_ind_pkg::SRC_RX: multi_configurable_indicator = rx_active;
      led_ind_pkg::SRC_COL: multi_configurable_indicator = collision;
      led_ind_pkg::SRC_100M: multi_configurable_indicator = speed_100;
      led_ind_pkg::SRC_10M: multi_configurable_indicator = !speed_100;
      led_ind_pkg::SRC_FULL_DUPLEX: multi_configurable_indicator = full_duplex;
      led_ind_pkg::SRC_LINK_BLINK: multi_configurable_indicator = link_blink;
      led_ind_pkg::SRC_STRETCH: multi_configurable_indicator = stretched;
      led_ind_pkg::SRC_FAST_FULL_LINK: begin
        multi_configurable_indicator = link_good & speed_100 & full_duplex;
      end
      default: multi_configurable_indicator = 1'b0;
    endcase
  end

  // pin values: [0] link, [1] speed, [2] activity, [3] collision
  always_comb begin
    pin_nxt[0] = (indicator_mode_select == MODE_PULSE) ? link_good : link_blink;
    pin_nxt[1] = speed_100;
    case (indicator_mode_select)
      MODE_PULSE: pin_nxt[2] = stretched;
      MODE_COLLISION: pin_nxt[2] = collision;
      MODE_DUPLEX: pin_nxt[2] = full_duplex;
      default: pin_nxt[2] = 1'b0;
    endcase
    pin_nxt[3] = collision;
    // routed multi indicator replaces the pin's normal function
    case (route)
      led_ind_pkg::ROUTE_LINK: pin_nxt[0] = multi_configurable_indicator;
      led_ind_pkg::ROUTE_SPEED: pin_nxt[1] = multi_configurable_indicator;
      led_ind_pkg::ROUTE_ACT: pin_nxt[2] = multi_configurable_indicator;
      led_ind_pkg::ROUTE_COL: pin_nxt[3] = multi_configurable_indicator;
      default: begin
      end
    endcase
    pin_nxt[2:0] = pin_nxt[2:0] ^ polarity;
  end

  // pin flops
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_r <= 4'h0;
    end else begin
      pin_r <= pin_nxt;
    end
  end

  // outputs; enables follow strap capture
  assign link_indicator_out = pin_r[0];
  assign speed_indicator_out = pin_r[1];
  assign activity_indicator_out = pin_r[2];
  assign collision_out = pin_r[3];
  assign link_indicator_oe = strap_done_r;
  assign speed_indicator_oe = strap_done_r;
  assign activity_indicator_oe = strap_done_r;
  assign collision_oe = strap_done_r;
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

endmodule // phy_led_indicator_control

// *** verilog/tick_divider.sv ***
// Purpose: divides the core clock into a one-cycle enable pulse
// Assumes: DIV of two or more
// Notes: free running from reset release
`timescale 1ns/1ps
module tick_divider #(
  parameter int unsigned DIV = 10000
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // enable out
  output logic tick
);

  logic [19:0] cnt_r;
  logic [19:0] cnt_nxt;
  logic tick_r;
  logic tick_nxt;

  // count up and wrap, pulse on the wrap
  always_comb begin
    if (cnt_r == 20'(DIV - 1)) begin
      cnt_nxt = 20'h00000;
      tick_nxt = 1'b1;
    end else begin
      cnt_nxt = cnt_r + 20'h00001;
      tick_nxt = 1'b0;
    end
  end

  // register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 20'h00000;
      tick_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick = tick_r;

endmodule // tick_divider
